// ===== inc/rbs_pkg.sv
package rbs_pkg;
    // word layout shared by register reads and serial output words
    localparam int          RBS_WORD_W      = 22;
    localparam int          RBS_DATA_W      = 16;
    localparam int          RBS_ALARM_BIT   = 21;
    localparam int          RBS_ADDR_HI     = 20;
    localparam int          RBS_ADDR_LO     = 16;
    localparam int          RBS_MODE_HI     = 6;
    localparam int          RBS_MODE_LO     = 5;
    localparam int          RBS_TGT_HI      = 4;
    localparam int          RBS_TGT_LO      = 0;
    // own address and value after reset
    localparam logic [4:0]  RBS_OWN_ADDR    = 5'h13;
    localparam logic [21:0] RBS_RESET_VAL   = 22'h130000;
    localparam logic [1:0]  RBS_MODE_RESET  = 2'h0;
    localparam logic [4:0]  RBS_TGT_RESET   = 5'h00;
    // readback target codes
    localparam logic [4:0]  RBS_T_NOP       = 5'h00;
    localparam logic [4:0]  RBS_T_IN_CODE   = 5'h01;
    localparam logic [4:0]  RBS_T_OUT_CODE  = 5'h02;
    localparam logic [4:0]  RBS_T_CLR_CODE  = 5'h03;
    localparam logic [4:0]  RBS_T_GAIN      = 5'h04;
    localparam logic [4:0]  RBS_T_OFFSET    = 5'h05;
    localparam logic [4:0]  RBS_T_CONV_CFG  = 5'h06;
    localparam logic [4:0]  RBS_T_SOFT_LOAD = 5'h07;
    localparam logic [4:0]  RBS_T_KEY       = 5'h08;
    localparam logic [4:0]  RBS_T_GEN_ONE   = 5'h09;
    localparam logic [4:0]  RBS_T_GEN_TWO   = 5'h0a;
    localparam logic [4:0]  RBS_T_LCHK_CFG  = 5'h10;
    localparam logic [4:0]  RBS_T_ALARM_MSK = 5'h12;
    localparam logic [4:0]  RBS_T_LCHK_RES  = 5'h14;
    localparam logic [4:0]  RBS_T_ACHK_RES  = 5'h15;
    localparam logic [4:0]  RBS_T_STATUS    = 5'h16;
    localparam logic [4:0]  RBS_T_PART_ID   = 5'h17;
    localparam logic [4:0]  RBS_T_RATE_WTCH = 5'h18;
    localparam logic [4:0]  RBS_T_PART_ID3  = 5'h1c;

    typedef enum logic [1:0] {
        RBS_TWO_STAGE   = 2'h0,
        RBS_AUTO_STATUS = 2'h1,
        RBS_SHARED_STAT = 2'h2,
        RBS_ALTERNATE   = 2'h3
    } rbs_mode_e;

    // what the serial output carries in a frame
    typedef enum logic [1:0] {
        RBS_OUT_NONE   = 2'h0,
        RBS_OUT_REG    = 2'h1,
        RBS_OUT_STATUS = 2'h3,
        RBS_OUT_ECHO   = 2'h2
    } rbs_out_e;
endpackage : rbs_pkg

// ===== sim/rbs_readback_tb_top.sv
module rbs_readback_tb_top
    import rbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, fs, fe, fw, fok, hm, alarm, drv, flag, ph;
    logic [4:0]  fa, tsel, t;
    logic [15:0] fd, st, tdat;
    logic [21:0] fi, ctrl, word, li;
    logic [1:0]  mode, kind, m, seen_kind;
    int          n_errors, tests_run;
    // mode, target and kind seen in the frame that writes them; reserved codes never sent
    localparam logic [8:0] rows [27] = '{9'h005, 9'h009, 9'h00d, 9'h011, 9'h015, 9'h019,
        9'h01d, 9'h021, 9'h025, 9'h029, 9'h041, 9'h049, 9'h04d, 9'h051, 9'h055, 9'h059,
        9'h05d, 9'h061, 9'h071, 9'h081, 9'h103, 9'h103, 9'h183, 9'h183, 9'h182, 9'h183,
        9'h016};

    rbs_readback rbs_readback_inst (.ref_clk_in(clk), .rst_in(rst), .frame_start_in(fs),
        .frame_end_in(fe), .frame_write_in(fw), .frame_ok_in(fok), .hw_addr_match_in(hm),
        .frame_addr_in(fa), .frame_data_in(fd), .frame_instr_in(fi), .status_in(st),
        .target_data_in(tdat), .alarm_pin_in(alarm), .target_sel_out(tsel), .mode_out(mode),
        .ctrl_read_out(ctrl), .sdo_word_out(word), .sdo_drive_out(drv), .sdo_kind_out(kind));
    rbs_reg_model rbs_reg_model_inst (.target_sel_in(tsel), .target_data_out(tdat),
        .status_out(st));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // word expected for a two-stage readback of code c
    function automatic logic [15:0] dat(input logic [4:0] c);
        return (c == 5'h13) ? {9'h0, m, t} : {3'h0, c, 3'h5, c};
    endfunction : dat

    // one frame: select fall, check the output word, then frame end with the given fields
    task automatic step(input logic w, input logic ok, input logic [4:0] a,
                        input logic [15:0] d);
        logic [24:0] e;
        logic [21:0] sw;
        sw = {1'b0, 5'h16, st};
        case (m)
            2'h0: e = {3'b101, 1'b0, t, dat(t)};
            2'h1: e = {3'b111, sw};
            2'h2: e = flag ? {3'b111, sw} : 25'h0;
            default: e = ph ? {3'b110, li} : {3'b111, sw};
        endcase
        @(posedge clk);
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        @(posedge clk);
        #1;
        seen_kind = kind;
        check({drv, kind, word}, e);
        @(posedge clk);
        {fe, fw, fok, fa, fd, fi} <= {1'b1, w, ok, a, d, w, a, d};
        @(posedge clk);
        fe <= 1'b0;
        repeat (2) @(posedge clk);
        ph = (m == 2'h3) ? ~ph : 1'b0;
        li = {w, a, d};
        flag = w & ok & hm;
        if (flag && a == 5'h13) begin
            {m, t} = d[6:0];
        end
        if (m != 2'h3) begin
            ph = 1'b0;
        end
    endtask : step

    task automatic do_reset(input int n);
        @(posedge clk);
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({drv, kind, ctrl}, {3'h0, 22'h130000});
        {m, t, flag, ph} = '0;
        $display("reset test done");
    endtask : do_reset

    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        conclude();
    end

    // main sequence
    initial begin
        {fs, fe, fw, fok, fa, fd, fi, alarm, li} = '0;
        rst = 1'b1;
        hm = 1'b1;
        do_reset(20);
        for (int i = 0; i < 27; i++) begin
            step(1'b1, 1'b1, 5'h13, {9'h0, rows[i][8:2]});
            check({23'h0, seen_kind}, {23'h0, rows[i][1:0]});
            #1;
            check({18'h0, mode, tsel}, {18'h0, m, t});
        end
        $display("table test done");
        step(1'b1, 1'b1, 5'h13, 16'hff8a);
        #1;
        check({3'h0, ctrl}, {3'h0, 22'h13000a});
        $display("reserved bits test done");
        step(1'b1, 1'b1, 5'h13, 16'h0040);
        step(1'b1, 1'b0, 5'h13, 16'h0000);
        step(1'b1, 1'b1, 5'h02, 16'h1234);
        @(posedge clk);
        hm <= 1'b0;
        step(1'b1, 1'b1, 5'h13, 16'h0000);
        @(posedge clk);
        hm <= 1'b1;
        step(1'b0, 1'b1, 5'h13, 16'h0000);
        step(1'b0, 1'b1, 5'h00, 16'h0000);
        #1;
        check({3'h0, ctrl}, {4'h0, 5'h13, 9'h0, 2'h2, t});
        $display("shared select test done");
        @(posedge clk);
        alarm <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({3'h0, ctrl}, {3'h0, 1'b1, 5'h13, 9'h0, m, t});
        @(posedge clk);
        alarm <= 1'b0;
        repeat (3) @(posedge clk);
        $display("alarm test done");
        do_reset(2);
        step(1'b0, 1'b1, 5'h00, 16'h0000);
        conclude();
    end
endmodule : rbs_readback_tb_top

// ===== sim/rbs_reg_model.sv
// stands for the rest of the device's register file behind the readback select
module rbs_reg_model
    import rbs_pkg::*;
(
    input  wire logic [4:0]            target_sel_in,
    output logic      [RBS_DATA_W-1:0] target_data_out,
    output logic      [RBS_DATA_W-1:0] status_out
);
    // each register returns a word built from its own code, so a wrong select shows up
    assign target_data_out = {3'h0, target_sel_in, 3'h5, target_sel_in};
    // status holds a fixed non-trivial pattern
    assign status_out      = 16'h5a3c;
endmodule : rbs_reg_model

// ===== verilog/rbs_readback.sv
// What this block does
// - two-bit style field, zero at reset, gives two-stage readback of selected register
// - style 01 shifts status out on every frame
// - style 10 sets a flag after each valid write addressed by address pins
// - style 10 drives status at select fall only when that flag is set
// - style 11 alternates status and echo of previous frame instruction
// - five-bit target field chooses two-stage register, reset selects no-operation
// - codes 1 to 10 select input code through second general setup
// - 0x10 check setup, 0x12-0x18 mask to rate watch, 0x1c third identity
// - bit 21 reads alarm pin level, read only, resets zero
// - bits 20 to 16 read only, carry own address
// - register lives at 0x13, reset value 0x130000
module rbs_readback
    import rbs_pkg::*;
(
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  frame_start_in,
    input  wire logic                  frame_end_in,
    input  wire logic                  frame_write_in,
    input  wire logic                  frame_ok_in,
    input  wire logic                  hw_addr_match_in,
    input  wire logic [4:0]            frame_addr_in,
    input  wire logic [RBS_DATA_W-1:0] frame_data_in,
    input  wire logic [RBS_WORD_W-1:0] frame_instr_in,
    input  wire logic [RBS_DATA_W-1:0] status_in,
    input  wire logic [RBS_DATA_W-1:0] target_data_in,
    input  wire logic                  alarm_pin_in,
    output logic      [4:0]            target_sel_out,
    output logic      [1:0]            mode_out,
    output logic      [RBS_WORD_W-1:0] ctrl_read_out,
    output logic      [RBS_WORD_W-1:0] sdo_word_out,
    output logic                       sdo_drive_out,
    output logic      [1:0]            sdo_kind_out
);

    rbs_mode_e              mode_reg;
    logic [4:0]             target_reg;
    logic                   alarm_reg;
    logic                   wr_flag_reg;
    logic                   phase_reg;
    logic [RBS_WORD_W-1:0]  prev_instr_reg;
    logic                   good_write;
    logic                   own_write;
    logic [RBS_WORD_W-1:0]  ctrl_word;
    logic [RBS_WORD_W-1:0]  sdo_word_next;
    logic                   sdo_drive_next;
    rbs_out_e               sdo_kind_next;

    // composes a register read word: alarm bit, given address field, low data
    function automatic logic [RBS_WORD_W-1:0] rbs_word(
        input logic                  alarm,
        input logic [4:0]            addr,
        input logic [RBS_DATA_W-1:0] data
    );
        rbs_word = {alarm, addr, data};
    endfunction : rbs_word

    // true for target codes that name a real register
    function automatic logic rbs_tgt_ok(input logic [4:0] code);
        case (code)
            5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h19, 5'h1a, 5'h1b,
            5'h1d, 5'h1e, 5'h1f: rbs_tgt_ok = 1'b0;
            default:             rbs_tgt_ok = 1'b1;
        endcase
    endfunction : rbs_tgt_ok

    // a write that passed checks and is addressed to this device
    assign good_write = frame_end_in && frame_write_in
                        && frame_ok_in && hw_addr_match_in;
    assign own_write  = good_write && (frame_addr_in == RBS_OWN_ADDR);

    // read view: alarm level, own address, zero reserved, mode, target
    assign ctrl_word = rbs_word(alarm_reg, RBS_OWN_ADDR,
                                {9'h000, mode_reg, target_reg});

    // writable fields, reserved and read-only bits ignored on write
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            mode_reg   <= rbs_mode_e'(RBS_MODE_RESET);
            target_reg <= RBS_TGT_RESET;
        end else if (own_write) begin
            mode_reg   <= rbs_mode_e'(frame_data_in[RBS_MODE_HI:RBS_MODE_LO]);
            target_reg <= frame_data_in[RBS_TGT_HI:RBS_TGT_LO];
        end
    end

    // alarm pin level sampled for the read-only bit
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= alarm_pin_in;
        end
    end

    // valid-write flag: a valid write sets it, any other frame end clears it
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wr_flag_reg <= 1'b0;
        end else if (good_write) begin
            wr_flag_reg <= 1'b1;
        end else if (frame_end_in) begin
            wr_flag_reg <= 1'b0;
        end
    end

    // previous frame instruction kept for echo
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            prev_instr_reg <= '0;
        end else if (frame_end_in) begin
            prev_instr_reg <= frame_instr_in;
        end
    end

    // alternating phase toggles on each frame start in style 11
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            phase_reg <= 1'b0;
        end else if (frame_start_in && mode_reg == RBS_ALTERNATE) begin
            phase_reg <= ~phase_reg;
        end else if (mode_reg != RBS_ALTERNATE) begin
            phase_reg <= 1'b0;
        end
    end

    // chooses what the serial output carries for the starting frame
    always_comb begin
        sdo_word_next  = '0;
        sdo_drive_next = 1'b0;
        sdo_kind_next  = RBS_OUT_NONE;
        case (mode_reg)
            RBS_TWO_STAGE: begin
                sdo_drive_next = 1'b1;
                sdo_kind_next  = RBS_OUT_REG;
                if (target_reg == RBS_OWN_ADDR) begin
                    sdo_word_next = ctrl_word;
                end else if (rbs_tgt_ok(target_reg)) begin
                    sdo_word_next = rbs_word(alarm_reg, target_reg,
                                             target_data_in);
                end else begin
                    sdo_word_next = rbs_word(alarm_reg, target_reg, '0);
                end
            end
            RBS_AUTO_STATUS: begin
                sdo_drive_next = 1'b1;
                sdo_kind_next  = RBS_OUT_STATUS;
                sdo_word_next  = rbs_word(alarm_reg, RBS_T_STATUS, status_in);
            end
            RBS_SHARED_STAT: begin
                if (wr_flag_reg) begin
                    sdo_drive_next = 1'b1;
                    sdo_kind_next  = RBS_OUT_STATUS;
                    sdo_word_next  = rbs_word(alarm_reg, RBS_T_STATUS, status_in);
                end
            end
            RBS_ALTERNATE: begin
                sdo_drive_next = 1'b1;
                if (phase_reg) begin
                    sdo_kind_next = RBS_OUT_ECHO;
                    sdo_word_next = prev_instr_reg;
                end else begin
                    sdo_kind_next = RBS_OUT_STATUS;
                    sdo_word_next = rbs_word(alarm_reg, RBS_T_STATUS, status_in);
                end
            end
            default: begin
                sdo_drive_next = 1'b0;
            end
        endcase
    end

    // serial output word latched at select fall, held for the frame
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sdo_word_out  <= '0;
            sdo_drive_out <= 1'b0;
            sdo_kind_out  <= RBS_OUT_NONE;
        end else if (frame_start_in) begin
            sdo_word_out  <= sdo_word_next;
            sdo_drive_out <= sdo_drive_next;
            sdo_kind_out  <= sdo_kind_next;
        end
    end

    // registered copies of the control fields and read view
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            target_sel_out <= RBS_TGT_RESET;
            mode_out       <= RBS_MODE_RESET;
            ctrl_read_out  <= RBS_RESET_VAL;
        end else begin
            target_sel_out <= target_reg;
            mode_out       <= mode_reg;
            ctrl_read_out  <= ctrl_word;
        end
    end

    // checks
    AST_RESET_DEFAULT: assert property (@(posedge ref_clk_in)
        $past(rst_in) |-> (mode_reg == RBS_TWO_STAGE && target_reg == RBS_TGT_RESET))
        else $error("style or target not at reset value");
    AST_AUTO_STATUS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (frame_start_in && mode_reg == RBS_AUTO_STATUS) |=> (sdo_drive_out
         && sdo_kind_out == RBS_OUT_STATUS && sdo_word_out[15:0] == $past(status_in)))
        else $error("status not driven in auto style");
    AST_FLAG_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        good_write |=> wr_flag_reg)
        else $error("valid write did not set flag");
    AST_SHARED_GATE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (frame_start_in && mode_reg == RBS_SHARED_STAT) |=> (sdo_drive_out == $past(wr_flag_reg)))
        else $error("shared style drove without flag");
    AST_ALTERNATE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (frame_start_in && mode_reg == RBS_ALTERNATE && phase_reg) |=>
        (sdo_kind_out == RBS_OUT_ECHO && sdo_word_out == $past(prev_instr_reg)))
        else $error("echo phase did not echo");
    AST_TARGET_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        own_write |=> ##1 (target_sel_out == $past(frame_data_in[4:0], 2)))
        else $error("target field not updated");
    AST_TWO_STAGE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (frame_start_in && mode_reg == RBS_TWO_STAGE && rbs_tgt_ok(target_reg)
         && target_reg != RBS_OWN_ADDR) |=> (sdo_word_out[15:0] == $past(target_data_in)))
        else $error("two-stage word not the target data");
    AST_ALARM_BIT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ##2 (ctrl_read_out[RBS_ALARM_BIT] == $past(alarm_pin_in, 2)))
        else $error("alarm bit does not follow pin");
    AST_OWN_ADDR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ctrl_read_out[RBS_ADDR_HI:RBS_ADDR_LO] == RBS_OWN_ADDR)
        else $error("address field wrong");
    AST_RESERVED_ZERO: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ctrl_read_out[15:7] == 9'h000)
        else $error("reserved bits not zero");

    COV_TWO_STAGE: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        frame_start_in && mode_reg == RBS_TWO_STAGE);
    COV_SHARED_ON: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        frame_start_in && mode_reg == RBS_SHARED_STAT && wr_flag_reg);
    COV_ALT_PAIR: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        (frame_start_in && mode_reg == RBS_ALTERNATE && !phase_reg) ##[1:50]
        (frame_start_in && phase_reg));

endmodule : rbs_readback
